// ==== twm_pkg.sv ====
package twm_pkg;
    // bus clock and bit timing
    localparam int TWM_CLK_NS = 25;
    localparam int TWM_QUARTER_NS = 2500;
    localparam int TWM_QUARTER_CYCLES =
        (TWM_QUARTER_NS / TWM_CLK_NS < 1) ? 1 : TWM_QUARTER_NS / TWM_CLK_NS;

    // apb register map
    localparam int TWM_ADDR_W = 4;
    localparam logic [3:0] TWM_CTRL_OFF = 4'h0;
    localparam logic [3:0] TWM_STATUS_OFF = 4'h4;
    localparam logic [3:0] TWM_DATA_OFF = 4'h8;

    // control register fields
    localparam int TWM_FLAG_BIT = 7;
    localparam int TWM_ACK_BIT = 6;
    localparam int TWM_START_BIT = 5;
    localparam int TWM_STOP_BIT = 4;
    localparam int TWM_WC_BIT = 3;
    localparam int TWM_EN_BIT = 2;
    localparam int TWM_IRQ_BIT = 0;

    // reset values
    localparam logic [7:0] TWM_DATA_RST = 8'hff;
    localparam logic [7:0] TWM_CODE_RST = 8'hf8;

    // status codes
    localparam logic [7:0] TWM_ST_START = 8'h08;
    localparam logic [7:0] TWM_ST_RSTART = 8'h10;
    localparam logic [7:0] TWM_ST_AW_ACK = 8'h18;
    localparam logic [7:0] TWM_ST_AW_NACK = 8'h20;
    localparam logic [7:0] TWM_ST_LOST = 8'h38;
    localparam logic [7:0] TWM_ST_AR_ACK = 8'h40;
    localparam logic [7:0] TWM_ST_AR_NACK = 8'h48;
    localparam logic [7:0] TWM_ST_RX_ACK = 8'h50;
    localparam logic [7:0] TWM_ST_RX_NACK = 8'h58;
    localparam logic [7:0] TWM_ST_IDLE = 8'hf8;

    // ninth clock of a byte carries the acknowledge
    localparam logic [3:0] TWM_ACK_SLOT = 4'h8;

    typedef enum logic [3:0] {
        S_IDLE, S_WAIT_FREE, S_START_A, S_START_B, S_HOLD, S_BIT_LOW,
        S_BIT_HIGH, S_RS_A, S_RS_B, S_STOP_A, S_STOP_B, S_LOST
    } twm_state_type;
endpackage : twm_pkg

// ==== twm_sync.sv ====
module twm_sync #(
    parameter int WIDTH = 2
) (
    input logic pclk,
    input logic presetn,
    input logic ce,
    input logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } twm_sync_type;

    twm_sync_type r;
    twm_sync_type next_r;

    // idle bus lines float high, so reset to ones
    always_comb begin
        next_r.first = d;
        next_r.second = r.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign q = r.second;
endmodule : twm_sync

// ==== twm_tick.sv ====
module twm_tick #(
    parameter int CYCLES = 100
) (
    input logic pclk,
    input logic presetn,
    input logic ce,
    output logic tick
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } twm_tick_type;

    twm_tick_type r;
    twm_tick_type next_r;

    always_comb begin
        next_r = r;
        next_r.tick = (r.cnt == LAST);
        next_r.cnt = (r.cnt == LAST) ? '0 : r.cnt + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule : twm_tick

// ==== twm_master_rx.sv ====
module twm_master_rx #(
    parameter int QUARTER_CYCLES = twm_pkg::TWM_QUARTER_CYCLES
) (
    input logic pclk,
    input logic presetn,
    input logic ce,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [twm_pkg::TWM_ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic master_tx_mode,
    output logic slave_mode
);
    import twm_pkg::*;

    typedef struct packed {
        twm_state_type state;
        logic flag;
        logic ack_en;
        logic start;
        logic stop;
        logic wc;
        logic en;
        logic irq_en;
        logic [7:0] code;
        logic [7:0] data;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic rx;
        logic is_read;
        logic rep;
        logic busy;
        logic sda_q;
        logic tx_mode;
        logic slave_mode;
        logic scl_oe_n;
        logic sda_oe_n;
        logic low_lvl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } twm_regs_type;

    twm_regs_type r;
    twm_regs_type next_r;

    logic tick;
    logic scl_s;
    logic sda_s;
    logic set_flag;
    logic setup;
    logic wr_ctrl;
    logic wr_data;
    logic release_sda;
    logic drive_bit;
    logic bit_done;

    twm_sync #(
        .WIDTH(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({scl_i, sda_i}),
        .q({scl_s, sda_s})
    );

    twm_tick #(
        .CYCLES(QUARTER_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(tick)
    );

    // no wait state: data is prepared in setup, ready in access
    assign setup = psel && !penable && !r.pready;
    assign wr_ctrl = psel && penable && r.pready && pwrite && paddr == TWM_CTRL_OFF;
    assign wr_data = psel && penable && r.pready && pwrite && paddr == TWM_DATA_OFF;

    // sda level wanted during the low half of a bit
    assign release_sda = r.rx ? ((r.cnt == TWM_ACK_SLOT) ? !r.ack_en : 1'b1)
                              : ((r.cnt == TWM_ACK_SLOT) || r.shift[7]);
    // bits in which this end drives sda and may lose arbitration
    assign drive_bit = r.rx ? (r.cnt == TWM_ACK_SLOT) : (r.cnt != TWM_ACK_SLOT);
    // high half ends only once the line is really high: slaves may stretch
    assign bit_done = r.state == S_BIT_HIGH && tick && scl_s;

    always_comb begin
        next_r = r;
        set_flag = 1'b0;
        next_r.pready = setup;
        if (setup) begin
            next_r.pslverr = 1'b0;
            next_r.prdata = '0;
            case (paddr)
                TWM_CTRL_OFF: begin
                    next_r.prdata[7:0] = {r.flag, r.ack_en, r.start, r.stop,
                                          r.wc, r.en, 1'b0, r.irq_en};
                end
                TWM_STATUS_OFF: begin
                    next_r.prdata[7:0] = {r.code[7:3], 3'h0};
                end
                TWM_DATA_OFF: begin
                    next_r.prdata[7:0] = r.data;
                end
                default: begin
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_ctrl) begin
            if (pwdata[TWM_FLAG_BIT]) begin
                next_r.flag = 1'b0;
            end
            next_r.ack_en = pwdata[TWM_ACK_BIT];
            next_r.start = pwdata[TWM_START_BIT];
            next_r.stop = pwdata[TWM_STOP_BIT];
            next_r.en = pwdata[TWM_EN_BIT];
            next_r.irq_en = pwdata[TWM_IRQ_BIT];
        end
        // data is only writable while the flag is up, else a collision
        if (wr_data) begin
            if (r.flag) begin
                next_r.data = pwdata[7:0];
                next_r.wc = 1'b0;
            end else begin
                next_r.wc = 1'b1;
            end
        end
        // bus busy tracking from start and stop conditions seen on the lines
        next_r.sda_q = sda_s;
        if (scl_s && r.sda_q && !sda_s) begin
            next_r.busy = 1'b1;
        end
        if (scl_s && !r.sda_q && sda_s) begin
            next_r.busy = 1'b0;
        end
        case (r.state)
            S_IDLE: begin
                next_r.scl_oe_n = 1'b1;
                next_r.sda_oe_n = 1'b1;
                if (r.start) begin
                    next_r.slave_mode = 1'b0;
                    next_r.state = S_WAIT_FREE;
                end
            end
            S_WAIT_FREE: begin
                if (!r.busy && scl_s && sda_s) begin
                    next_r.state = S_START_A;
                end
            end
            S_START_A: begin
                if (tick) begin
                    next_r.sda_oe_n = 1'b0;
                    next_r.state = S_START_B;
                end
            end
            // start code / repeated start code
            S_START_B: begin
                if (tick) begin
                    next_r.scl_oe_n = 1'b0;
                    set_flag = 1'b1;
                    next_r.code = r.rep ? TWM_ST_RSTART : TWM_ST_START;
                    next_r.rep = 1'b1;
                    next_r.state = S_HOLD;
                end
            end
            S_HOLD: begin
                next_r.scl_oe_n = 1'b0;
                if (!r.flag) begin
                    next_r.cnt = '0;
                    case (r.code)
                        TWM_ST_START, TWM_ST_RSTART: begin
                            next_r.shift = r.data;
                            next_r.is_read = r.data[0];
                            next_r.rx = 1'b0;
                            next_r.state = S_BIT_LOW;
                        end
                        TWM_ST_AR_ACK, TWM_ST_RX_ACK: begin
                            next_r.rx = 1'b1;
                            next_r.state = S_BIT_LOW;
                        end
                        default: begin
                            if (r.stop) begin
                                next_r.state = S_STOP_A;
                            end else if (r.start) begin
                                next_r.state = S_RS_A;
                            end
                        end
                    endcase
                end
            end
            S_BIT_LOW: begin
                next_r.sda_oe_n = release_sda;
                // scl rises only once sda has settled, else a false start or stop
                if (tick && r.sda_oe_n == release_sda) begin
                    next_r.scl_oe_n = 1'b1;
                    next_r.state = S_BIT_HIGH;
                end
            end
            S_BIT_HIGH: begin
                if (bit_done) begin
                    if (r.sda_oe_n && !sda_s && drive_bit) begin
                        next_r.scl_oe_n = 1'b1;
                        next_r.sda_oe_n = 1'b1;
                        set_flag = 1'b1;
                        next_r.code = TWM_ST_LOST;
                        next_r.state = S_LOST;
                    end else if (r.cnt == TWM_ACK_SLOT) begin
                        next_r.scl_oe_n = 1'b0;
                        set_flag = 1'b1;
                        next_r.state = S_HOLD;
                        if (r.rx) begin
                            next_r.data = r.shift;
                            next_r.code = r.sda_oe_n ? TWM_ST_RX_NACK : TWM_ST_RX_ACK;
                        end else if (r.is_read) begin
                            next_r.code = sda_s ? TWM_ST_AR_NACK : TWM_ST_AR_ACK;
                            next_r.tx_mode = 1'b0;
                        end else begin
                            next_r.tx_mode = 1'b1;
                            next_r.code = sda_s ? TWM_ST_AW_NACK : TWM_ST_AW_ACK;
                        end
                    end else begin
                        next_r.scl_oe_n = 1'b0;
                        next_r.cnt = r.cnt + 4'h1;
                        next_r.shift = {r.shift[6:0], sda_s};
                        next_r.state = S_BIT_LOW;
                    end
                end
            end
            S_RS_A: begin
                next_r.sda_oe_n = 1'b1;
                if (tick && r.sda_oe_n) begin
                    next_r.scl_oe_n = 1'b1;
                    next_r.state = S_RS_B;
                end
            end
            S_RS_B: begin
                if (tick && scl_s) begin
                    next_r.state = S_START_A;
                end
            end
            S_STOP_A: begin
                next_r.sda_oe_n = 1'b0;
                if (tick && !r.sda_oe_n) begin
                    next_r.scl_oe_n = 1'b1;
                    next_r.state = S_STOP_B;
                end
            end
            S_STOP_B: begin
                if (tick && scl_s) begin
                    next_r.sda_oe_n = 1'b1;
                    next_r.stop = 1'b0;
                    next_r.rep = 1'b0;
                    next_r.tx_mode = 1'b0;
                    next_r.code = TWM_ST_IDLE;
                    next_r.state = r.start ? S_WAIT_FREE : S_IDLE;
                end
            end
            S_LOST: begin
                next_r.scl_oe_n = 1'b1;
                next_r.sda_oe_n = 1'b1;
                if (!r.flag) begin
                    next_r.rep = 1'b0;
                    next_r.tx_mode = 1'b0;
                    if (r.start) begin
                        next_r.state = S_WAIT_FREE;
                    end else begin
                        next_r.slave_mode = 1'b1;
                        next_r.code = TWM_ST_IDLE;
                        next_r.state = S_IDLE;
                    end
                end
            end
            default: begin
                next_r.state = S_IDLE;
            end
        endcase
        // disabled interface lets go of both lines at once
        if (!r.en) begin
            next_r.state = S_IDLE;
            next_r.scl_oe_n = 1'b1;
            next_r.sda_oe_n = 1'b1;
            next_r.rep = 1'b0;
        end
        if (set_flag) begin
            next_r.flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.state <= S_IDLE;
            r.data <= TWM_DATA_RST;
            r.code <= TWM_CODE_RST;
            r.shift <= TWM_DATA_RST;
            r.sda_q <= 1'b1;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign scl_o = r.low_lvl;
    assign sda_o = r.low_lvl;
    assign scl_oe_n = r.scl_oe_n;
    assign sda_oe_n = r.sda_oe_n;
    assign master_tx_mode = r.tx_mode;
    assign slave_mode = r.slave_mode;

    a_hold_scl_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r.state == S_HOLD && r.flag) |=> !r.scl_oe_n)
        else $error("clock line released while flag set");

    a_flag_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_ctrl && pwdata[TWM_FLAG_BIT] && !set_flag) |=> !r.flag)
        else $error("flag not cleared by write of one");

    a_flag_set_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && set_flag) |=> r.flag)
        else $error("hardware flag set was lost");

    a_start_free: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && r.state == S_WAIT_FREE && !r.busy && scl_s && sda_s)
        |=> r.state == S_START_A)
        else $error("start not begun on free bus");

    a_start_code: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && r.state == S_START_B && tick && !r.rep)
        |=> r.flag && r.code == TWM_ST_START && !r.scl_oe_n)
        else $error("start code not reported");

    a_rstart_code: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && r.state == S_START_B && tick && r.rep)
        |=> r.flag && r.code == TWM_ST_RSTART && r.state == S_HOLD)
        else $error("repeated start code not reported");

    a_addr_code: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && bit_done && !r.rx && r.is_read && r.cnt == TWM_ACK_SLOT)
        |=> r.flag && (r.code == TWM_ST_AR_ACK || r.code == TWM_ST_AR_NACK
                       || r.code == TWM_ST_LOST))
        else $error("address acknowledge code wrong");

    a_rx_data: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && bit_done && r.rx && r.cnt == TWM_ACK_SLOT && !set_flag == 1'b0
         && r.state == S_BIT_HIGH && !(r.sda_oe_n && !sda_s && drive_bit))
        |=> r.flag && r.data == $past(r.shift))
        else $error("received byte not in data register");

    a_write_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && bit_done && !r.rx && !r.is_read && r.cnt == TWM_ACK_SLOT)
        |=> r.tx_mode && r.code == ($past(sda_s) ? TWM_ST_AW_NACK : TWM_ST_AW_ACK))
        else $error("write address did not switch mode");

    a_lost_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && r.state == S_LOST && !r.flag && !r.start)
        |=> r.slave_mode && r.state == S_IDLE && r.scl_oe_n && r.sda_oe_n)
        else $error("lost arbitration did not release bus");

    a_nack_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && r.state == S_HOLD && !r.flag && r.stop
         && (r.code == TWM_ST_AR_NACK || r.code == TWM_ST_RX_NACK))
        |=> r.state == S_STOP_A)
        else $error("stop not started after nack");

    a_stop_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && r.state == S_STOP_B && tick && scl_s)
        |=> !r.stop && r.sda_oe_n)
        else $error("stop bit not cleared after stop");

    a_scl_waits_sda: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && r.en && r.state == S_BIT_LOW && r.sda_oe_n != release_sda)
        |=> !r.scl_oe_n)
        else $error("clock line released before data settled");
endmodule : twm_master_rx

// ==== twm_slave_model.sv ====
module twm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a,
    parameter logic [7:0] FIRST = 8'ha5
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe_n,
    output logic master_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh;
    logic [7:0] tx;
    logic act = 1'b0;
    logic dat;
    logic hit;
    int n;
    initial begin
        sda_oe_n = 1'b1;
        master_ack = 1'b0;
    end
    // start, repeated start or stop seen while the clock line is high
    always @(sda) begin
        if (scl === 1'b1) begin
            act = !sda;
            dat = 1'b0;
            n = -1;
            tx = FIRST;
        end
    end
    always @(posedge scl) begin
        if (act && !dat && n < 8) begin
            sh = {sh[6:0], sda};
        end
        if (act && dat && n == 8) begin
            master_ack = !sda;
        end
    end
    // bits change only while the clock line is low; released means pulled up
    always @(negedge scl) begin
        if (act) begin
            n = n + 1;
            if (n == 9) begin
                n = 0;
                act = dat ? master_ack : hit;
                tx = dat ? tx + 8'h3c : tx;
                dat = 1'b1;
            end
            hit = dat ? hit : (sh == {ADDR, 1'b1});
        end
        sda_oe_n = 1'b1;
        if (act && !dat && n == 8) begin
            sda_oe_n = !hit;
        end
        if (act && dat && n < 8) begin
            sda_oe_n = tx[7-n];
        end
    end
endmodule : twm_slave_model

// ==== twm_master_rx_bench.sv ====
module twm_master_rx_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import twm_pkg::*;
    localparam logic [6:0] SLV = 7'h2a;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic scl_oe_n, sda_oe_n, tx_mode, slv_mode, m_oe_n, m_ack, rival;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata, r;
    int errors, samples_checked, cyc;
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & m_oe_n & ~rival;

    twm_master_rx #(.QUARTER_CYCLES(3)) uut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl), .scl_o(),
        .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n),
        .master_tx_mode(tx_mode), .slave_mode(slv_mode));
    twm_slave_model #(.ADDR(SLV)) partner (
        .scl(scl), .sda(sda), .sda_oe_n(m_oe_n), .master_ack(m_ack));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [3:0] a);
        apb(1'b0, a, 8'h00);
    endtask : rd

    task automatic ctl(input logic ack, input logic strt, input logic stp);
        apb(1'b1, TWM_CTRL_OFF, {1'b1, ack, strt, stp, 4'h4});
    endtask : ctl

    task automatic wait_code(input logic [7:0] c);
        int i;
        rd(TWM_STATUS_OFF);
        for (i = 0; i < 800 && r[7:0] !== c; i++) rd(TWM_STATUS_OFF);
        chk("status", r, {24'h0, c});
        rd(TWM_CTRL_OFF);
        chk("flag", r[7], c != TWM_ST_IDLE);
        if (c != TWM_ST_LOST && c != TWM_ST_IDLE) chk("scl held", scl_oe_n, 0);
    endtask : wait_code

    task automatic t_regs;
        rd(TWM_CTRL_OFF);
        chk("ctrl rst", r, 0);
        rd(TWM_DATA_OFF);
        chk("data rst", r, 32'hff);
        rd(4'hc);
        chk("unmapped", e, 1);
        apb(1'b1, TWM_STATUS_OFF, 8'h00);
        rd(TWM_STATUS_OFF);
        chk("status ro", r, 32'hf8);
        apb(1'b1, TWM_DATA_OFF, 8'h12);
        rd(TWM_CTRL_OFF);
        chk("collision", r[3], 1);
    endtask : t_regs

    task automatic t_read;
        ctl(1, 1, 0);
        wait_code(TWM_ST_START);
        apb(1'b1, TWM_DATA_OFF, {SLV, 1'b1});
        ctl(1, 0, 0);
        wait_code(TWM_ST_AR_ACK);
        ctl(1, 0, 0);
        wait_code(TWM_ST_RX_ACK);
        chk("ack out", m_ack, 1);
        rd(TWM_DATA_OFF);
        chk("byte0", r, 32'ha5);
        // ack enable cleared before last byte
        ctl(0, 0, 0);
        wait_code(TWM_ST_RX_NACK);
        chk("nack out", m_ack, 0);
        rd(TWM_DATA_OFF);
        chk("byte1", r, 32'he1);
        ctl(0, 1, 0);
        wait_code(TWM_ST_RSTART);
        apb(1'b1, TWM_DATA_OFF, {SLV, 1'b0});
        ctl(0, 0, 0);
        wait_code(TWM_ST_AW_NACK);
        chk("tx mode", tx_mode, 1);
        ctl(0, 1, 0);
        wait_code(TWM_ST_RSTART);
        apb(1'b1, TWM_DATA_OFF, {7'h11, 1'b1});
        ctl(0, 0, 0);
        wait_code(TWM_ST_AR_NACK);
        chk("rx mode", tx_mode, 0);
        ctl(0, 1, 1);
        wait_code(TWM_ST_START);
        chk("stop bit", r[4], 0);
        // same address again; the stop follows its nack
        ctl(0, 0, 0);
        wait_code(TWM_ST_AR_NACK);
        ctl(0, 0, 1);
        wait_code(TWM_ST_IDLE);
        chk("sda free", sda, 1);
    endtask : t_read

    task automatic t_lost;
        ctl(0, 1, 0);
        wait_code(TWM_ST_START);
        apb(1'b1, TWM_DATA_OFF, 8'hff);
        ctl(0, 0, 0);
        rival <= 1'b1;
        wait_code(TWM_ST_LOST);
        rival <= 1'b0;
        ctl(0, 0, 0);
        repeat (4) @(posedge pclk);
        chk("slave mode", slv_mode, 1);
        chk("scl free", scl, 1);
    endtask : t_lost

    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // a hung handshake ends the run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            give_verdict;
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 4'h0;
        pwdata = 32'h0;
        rival = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_read;
        t_lost;
        give_verdict;
    end
endmodule : twm_master_rx_bench
